// [acp_ctrl_model.sv]
// acp_ctrl_model.sv - serial controller model: strobe, shift clock, config bits
// assumes a 100 MHz core behind the port; shift clock stands low outside frames
`timescale 1ns/100ps
module acp_ctrl_model (
  output logic strobe,
  output logic shift_clk,
  output logic cfg_out,
  input wire logic res_out,
  input wire logic res_oe,
  input wire logic sleep,
  input wire logic sample
);
  logic held;
  // a released line shows the inverse of its last bit, so stale data cannot pass
  wire line = res_oe ? res_out : ~held;
  always @(res_out or res_oe) if (res_oe) held = res_out;
  initial begin
    strobe = 1'b0;
    shift_clk = 1'b0;
    cfg_out = 1'b0;
    held = 1'b0;
  end
  // strobe high long enough for the 3.2 us standard-grade conversion plus pin sync
  task automatic convert();
    strobe = 1'b1;
    #3260;
  endtask : convert
  // one frame of 20 shift periods, then strobe up for the next conversion
  task automatic xfer(input logic [1:0] cfg, output logic [19:0] got,
                      output logic [3:0] flags);
    strobe = 1'b0;
    cfg_out = cfg[1];
    #120;
    flags = {res_oe, sleep, 2'b00};
    // acquisition window probed at its last open and first closed period
    for (int i = 0; i < 20; i++) begin
      got = {got[18:0], line};
      if (i == 13) flags[1] = sample;
      if (i == 14) flags[0] = sample;
      shift_clk = 1'b1;
      #40;
      shift_clk = 1'b0;
      cfg_out = (i == 0) ? cfg[0] : ~cfg_out;
      #40;
    end
    strobe = 1'b1;
    #3260;
  endtask : xfer
endmodule : acp_ctrl_model

// [acp_fifo.sv]
// acp_fifo.sv - small result buffer with valid/ready on both sides
// assumes one clock and an active low asynchronous reset
`timescale 1ns/100ps
module acp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [WIDTH-1:0] IN_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [WIDTH-1:0] OUT_DATA
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign IN_READY = (cnt_ff != (AW+1)'(DEPTH));
  assign OUT_VALID = (cnt_ff != '0);
  assign OUT_DATA = mem_ff[rd_ff];
  assign push = IN_VALID && IN_READY;
  assign pop = OUT_VALID && OUT_READY;

  // storage has no reset; only pointers and count need a defined value
  always_ff @(posedge CORE_CLK) begin
    if (push) begin
      mem_ff[wr_ff] <= IN_DATA;
    end
  end

  // pointers and count
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : acp_fifo

// [acp_map.svh]
// acp_map.svh - constants for the converter serial conversion port
// assumes a 100 MHz core clock; shift clock and strobe arrive as async pins
// How it works
// - rising convert strobe starts conversion of the held sample
// - conversion ends within 3.2 us, or 3.3 us for hot grade
// - strobe still high at conversion end puts converter to sleep until strobe falls
// - strobe low: serial result output is driven
// - strobe rising: serial result output released to high impedance
// - input acquired while strobe low, 16 periods or 14 on two-channel part
// - each new output bit appears after a falling shift edge
// - two-channel part takes its config word serially on config input
// - result shifted out one bit per shift period
// - first two rising edges after strobe falls give config, rest ignored
// - config 10 single zero, 11 single one, 00 zero over one, 01 one over zero
// - after full result, further shift periods give zeros
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH
`define ACP_CLK_MHZ 100
`define ACP_CONVERT_NS 3200
`define ACP_CONVERT_HOT_NS 3300
`define ACP_CONVERT_CYC ((`ACP_CONVERT_NS * `ACP_CLK_MHZ) / 1000)
`define ACP_CONVERT_HOT_CYC ((`ACP_CONVERT_HOT_NS * `ACP_CLK_MHZ) / 1000)
`define ACP_RES_BITS 16
`define ACP_CFG_BITS 2
`define ACP_SMPL_ONE 16
`define ACP_SMPL_TWO 14
`define ACP_FIFO_DEPTH 4
`endif

// [acp_pkg.sv]
// acp_pkg.sv - types of the converter serial conversion port
// assumes acp_map.svh for all numeric constants
package acp_pkg;
  typedef enum logic [1:0] {
    ACP_IDLE = 2'b00,
    ACP_CONVERT = 2'b01,
    ACP_SLEEP = 2'b10,
    ACP_XFER = 2'b11
  } acp_state_t;
  // input selection decoded from the config word
  typedef enum logic [1:0] {
    ACP_DIFF_01 = 2'b00,
    ACP_DIFF_10 = 2'b01,
    ACP_SGL_0 = 2'b10,
    ACP_SGL_1 = 2'b11
  } acp_mux_t;
endpackage : acp_pkg

// [acp_port.sv]
// acp_port.sv - convert strobe control and serial result/config port
// assumes strobe, shift clock and config input are asynchronous pins, the
// shift clock far slower than CORE_CLK; the analog core offers results
// on a valid/ready stream and takes the selected mux setting.
`timescale 1ns/100ps
`include "acp_map.svh"
module acp_port #(
  parameter bit TWO_CHANNEL = 1'b1,
  parameter bit HOT_GRADE = 1'b0
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic CONVERT_STROBE,
  input wire logic SHIFT_CLK,
  input wire logic SERIAL_CONFIG_IN,
  output logic SERIAL_RESULT_OUT,
  output logic SERIAL_RESULT_OE,
  input wire logic RESULT_VALID,
  output logic RESULT_READY,
  input wire logic [15:0] RESULT_DATA,
  output logic CONVERT_START,
  output logic SAMPLE_ACTIVE,
  output logic SLEEP,
  output acp_pkg::acp_mux_t MUX_SEL
);
  import acp_pkg::*;
  localparam int CONVERT_CYCLES = HOT_GRADE ? `ACP_CONVERT_HOT_CYC : `ACP_CONVERT_CYC;
  localparam logic [4:0] SMPL = TWO_CHANNEL ? 5'(`ACP_SMPL_TWO) : 5'(`ACP_SMPL_ONE);

  logic [2:0] cv_sync_ff;
  logic [2:0] sk_sync_ff;
  logic [1:0] di_sync_ff;
  logic cv_rise;
  logic cv_fall;
  logic sk_rise;
  logic sk_fall;
  acp_state_t state_ff;
  acp_state_t nxt_state;
  logic [8:0] convert_cnt_ff;
  logic [15:0] shift_ff;
  logic [4:0] bit_cnt_ff;
  logic [1:0] cfg_ff;
  logic [1:0] cfg_cnt_ff;
  logic out_ff;
  logic oe_ff;
  logic fifo_valid;
  logic [15:0] fifo_data;
  logic take;

  // two flops before use; the third stage only feeds edge detection
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cv_sync_ff <= 3'h0;
      sk_sync_ff <= 3'h0;
      di_sync_ff <= 2'h0;
    end else begin
      cv_sync_ff <= {cv_sync_ff[1:0], CONVERT_STROBE};
      sk_sync_ff <= {sk_sync_ff[1:0], SHIFT_CLK};
      di_sync_ff <= {di_sync_ff[0], SERIAL_CONFIG_IN};
    end
  end
  assign cv_rise = cv_sync_ff[1] && !cv_sync_ff[2];
  assign cv_fall = !cv_sync_ff[1] && cv_sync_ff[2];
  assign sk_rise = sk_sync_ff[1] && !sk_sync_ff[2];
  assign sk_fall = !sk_sync_ff[1] && sk_sync_ff[2];

  // result buffer between analog core and the shifter
  acp_fifo #(.WIDTH(`ACP_RES_BITS), .DEPTH(`ACP_FIFO_DEPTH)) u_fifo (
    .CORE_CLK(CORE_CLK),
    .RST_B(RST_B),
    .IN_VALID(RESULT_VALID),
    .IN_READY(RESULT_READY),
    .IN_DATA(RESULT_DATA),
    .OUT_VALID(fifo_valid),
    .OUT_READY(take),
    .OUT_DATA(fifo_data)
  );
  // a result is loaded for shifting when the strobe falls
  assign take = cv_fall && fifo_valid;

  // conversion, sleep and transfer sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ACP_IDLE: if (cv_rise) nxt_state = ACP_CONVERT;
      ACP_CONVERT: begin
        if (convert_cnt_ff == 9'(CONVERT_CYCLES - 1)) begin
          nxt_state = cv_sync_ff[1] ? ACP_SLEEP : ACP_XFER;
        end
      end
      ACP_SLEEP: if (cv_fall) nxt_state = ACP_XFER;
      ACP_XFER: if (cv_rise) nxt_state = ACP_CONVERT;
      default: nxt_state = ACP_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff <= ACP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // conversion time counter restarts on every strobe rise
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      convert_cnt_ff <= 9'h000;
    end else if (cv_rise || state_ff != ACP_CONVERT) begin
      convert_cnt_ff <= 9'h000;
    end else begin
      convert_cnt_ff <= convert_cnt_ff + 9'h001;
    end
  end
  assign CONVERT_START = cv_rise;

  // result shifter: msb first, zeros once the word is out
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      shift_ff <= 16'h0000;
      bit_cnt_ff <= 5'h00;
      out_ff <= 1'b0;
    end else if (cv_fall) begin
      shift_ff <= fifo_valid ? fifo_data : 16'h0000;
      bit_cnt_ff <= 5'h00;
      out_ff <= fifo_valid ? fifo_data[15] : 1'b0;
    end else if (!cv_sync_ff[1] && sk_fall) begin
      shift_ff <= {shift_ff[14:0], 1'b0};
      if (bit_cnt_ff != 5'(`ACP_RES_BITS)) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
      out_ff <= shift_ff[14];
    end
  end

  // output enable follows the synchronised strobe level
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= !cv_sync_ff[1] && !cv_rise;
    end
  end
  assign SERIAL_RESULT_OUT = out_ff;
  assign SERIAL_RESULT_OE = oe_ff;

  // config word: first two rising edges after the strobe falls, then ignored
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_ff <= 2'h2;
      cfg_cnt_ff <= 2'h0;
    end else if (cv_fall) begin
      cfg_cnt_ff <= 2'h0;
    end else if (TWO_CHANNEL && !cv_sync_ff[1] && sk_rise
                 && cfg_cnt_ff != 2'(`ACP_CFG_BITS)) begin
      cfg_ff <= {cfg_ff[0], di_sync_ff[1]};
      cfg_cnt_ff <= cfg_cnt_ff + 2'h1;
    end
  end
  // the first bit taken is single_ended_select, the second picks the odd side
  assign MUX_SEL = TWO_CHANNEL ? acp_mux_t'(cfg_ff) : ACP_DIFF_01;
  assign SLEEP = (state_ff == ACP_SLEEP);
  // sampling lasts while the strobe is low and the acquisition window is open
  assign SAMPLE_ACTIVE = (state_ff == ACP_XFER) && !cv_sync_ff[1]
                         && (bit_cnt_ff < SMPL);

  sleep_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (state_ff == ACP_SLEEP) && cv_sync_ff[1] |=> state_ff == ACP_SLEEP)
    else $error("sleep left while strobe high");
  convert_time_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (state_ff == ACP_CONVERT) |-> convert_cnt_ff < 9'(CONVERT_CYCLES))
    else $error("conversion overran its time");
  start_convert_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    cv_rise |=> state_ff == ACP_CONVERT)
    else $error("strobe rise did not start conversion");
  drive_low_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !cv_sync_ff[1] && !cv_rise ##1 !cv_sync_ff[1] |-> oe_ff)
    else $error("output not driven with strobe low");
  release_hiz_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    cv_sync_ff[1] |=> !oe_ff)
    else $error("output driven with strobe high");
  msb_first_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    cv_fall && fifo_valid |=> out_ff == $past(fifo_data[15]))
    else $error("first bit is not msb");
  shift_fall_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    $changed(out_ff) |-> $past(sk_fall) || $past(cv_fall))
    else $error("output changed without falling edge");
  zero_tail_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    bit_cnt_ff == 5'(`ACP_RES_BITS) && !cv_sync_ff[1] |-> !out_ff)
    else $error("nonzero after full result");
  cfg_limit_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    cfg_cnt_ff == 2'(`ACP_CFG_BITS) && !cv_fall |=> $stable(cfg_ff))
    else $error("config changed after two bits");
  sleep_c: cover property (@(posedge CORE_CLK) state_ff == ACP_SLEEP);
  full_word_c: cover property (@(posedge CORE_CLK) bit_cnt_ff == 5'(`ACP_RES_BITS));
  cfg_done_c: cover property (@(posedge CORE_CLK) cfg_cnt_ff == 2'(`ACP_CFG_BITS));
  xfer_shift_c: cover property (@(posedge CORE_CLK) state_ff == ACP_XFER && sk_fall);
endmodule : acp_port

// [acp_port_bench.sv]
// acp_port_bench.sv - self-checking bench for the conversion port
// assumes acp_ctrl_model plays the controller; bench feeds the result stream
`timescale 1ns/100ps
module adc_serial_conversion_port_bench;
  import acp_pkg::*;
  logic core_clk, rst_b, res_valid;
  logic [15:0] res_data;
  wire strobe, shift_clk, cfg_in, res_out, res_oe, res_ready, convert_start, sample, sleep;
  acp_mux_t mux_sel;
  int n_fail, checks, cycles, n_start;
  logic [15:0] words [4] = '{16'h7FFE, 16'hFFFF, 16'h8000, 16'h5AA5};
  acp_port #(.TWO_CHANNEL(1'b1), .HOT_GRADE(1'b0)) dut (.CORE_CLK(core_clk),
    .RST_B(rst_b), .CONVERT_STROBE(strobe), .SHIFT_CLK(shift_clk),
    .SERIAL_CONFIG_IN(cfg_in), .SERIAL_RESULT_OUT(res_out), .SERIAL_RESULT_OE(res_oe),
    .RESULT_VALID(res_valid), .RESULT_READY(res_ready), .RESULT_DATA(res_data),
    .CONVERT_START(convert_start), .SAMPLE_ACTIVE(sample), .SLEEP(sleep), .MUX_SEL(mux_sel));
  acp_ctrl_model model (.strobe(strobe), .shift_clk(shift_clk), .cfg_out(cfg_in),
    .res_out(res_out), .res_oe(res_oe), .sleep(sleep), .sample(sample));
  always #5 core_clk = ~core_clk;
  // start pulses counted here; the cycle ceiling is several times the run length
  always @(posedge core_clk) begin
    cycles++;
    if (convert_start === 1'b1) n_start++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // outputs while reset is held
  task automatic t_reset_values();
    chk({res_oe, res_out, sleep, mux_sel, res_ready}, {3'b000, ACP_SGL_0, 1'b1});
  endtask : t_reset_values
  // push until the buffer refuses; the port drains nothing while strobe is low
  task automatic t_fill_buffer();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      res_valid <= 1'b1;
      res_data <= words[i];
      #1;
      chk(20'(res_ready), 20'h1);
    end
    @(posedge core_clk);
    res_valid <= 1'b0;
    #1;
    chk(20'(res_ready), 20'h0);
  endtask : t_fill_buffer
  // four frames, one per config code, each followed by a conversion
  task automatic t_frames();
    logic [1:0] codes [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
    acp_mux_t sel [4] = '{ACP_SGL_0, ACP_SGL_1, ACP_DIFF_01, ACP_DIFF_10};
    logic [19:0] got;
    logic [3:0] flags;
    int starts;
    for (int i = 0; i < 4; i++) begin
      starts = n_start;
      model.xfer(codes[i], got, flags);
      chk(got, {words[i], 4'h0});
      chk(20'(mux_sel), 20'(sel[i]));
      chk(20'(flags), 20'hA);
      chk(20'({res_oe, sleep}), 20'h1);
      chk(20'(n_start - starts), 20'h1);
    end
  endtask : t_frames
  // empty buffer at strobe fall: the frame carries only zeros
  task automatic t_empty_frame();
    logic [19:0] got;
    logic [3:0] flags;
    model.xfer(2'b11, got, flags);
    chk(got, 20'h0);
    chk(20'({res_ready, mux_sel}), 20'(3'b111));
  endtask : t_empty_frame
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    res_valid = 1'b0;
    res_data = 16'h0000;
    repeat (2) @(posedge core_clk);
    #1;
    t_reset_values();
    repeat (14) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_fill_buffer();
    model.convert();
    t_frames();
    t_empty_frame();
    finish_test();
  end
endmodule : adc_serial_conversion_port_bench
